// *** rtl/spm_core.sv ***
`timescale 1ns/10ps
// Functional notes
// R1 - message_only_select set: message code byte0, lun byte1 of word 08h
// R2 - message form uses only id, target, code, lun and select bit
// R3 - accept codes 06h, 0ch, 0eh; select target, send that message only
// R4 - any other code: no message, error status with code 01h
// R5 - lun is the top three bits of the lun byte
// R6 - status block: id 00h, rsvd/status/error/flags 04h, sense 08h-0ch
// R7 - command identifier copied into every status block
// R8 - flags bit 0 cleared and bit 1 held zero
// R9 - continued_report_flag set on every block after the first
// R10 - transfer_over_flag set when target asked for more than count
// R11 - transfer_short_flag set when fewer bytes moved than count
// R12 - retried_flag set when retries were needed
// R13 - error flag set when a command completes with an error
// R14 - done_flag set when the command has finished
// R15 - device-detected error code placed in error byte
// R16 - status phase byte placed in scsi status field, bits 5..1
// R17 - unexpected phase: error 24h, phase msg/cd/io in bits 2..0
// R18 - phase codes 000..111 as scsi, 100 and 101 reserved
// R19 - request sense issued on check condition unless inhibited
// R20 - sense reported default 8, up to 32 sequential, or 16 selected
// R21 - more than eight sense bytes split over blocks, eight each
// R22 - sense fields zero if no check condition or sense inhibited
// R23 - default eight bytes when count and every selection are zero
// R24 - all other fields written before done_flag is set
module spm_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic msg_send_ff,
   output logic [7:0] msg_code_ff,
   output logic [2:0] msg_lun_ff,
   output logic [7:0] msg_target_ff,
   output logic sense_req_ff
);
   import spm_pkg::*;

   // ************************************************************
   // apb access decode
   // ************************************************************
   logic wr_en;
   logic rd_en;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign pready = 1'b1;

   logic [31:0] cmd_id_ff;
   logic [31:0] pb_flags_ff;
   logic [31:0] pb_msg_ff;
   logic [31:0] xfer_ff;
   logic [5:0] sense_cnt_ff;
   logic [7:0] sel_ff [SENSE_SEL_MAX];
   logic [7:0] sbuf_ff [SENSE_SEQ_MAX];
   logic [7:0] sbuf_wr_ptr_ff;
   logic [31:0] sb_word1_ff;
   logic [63:0] sb_sense_ff;
   logic [1:0] blk_idx_ff;
   logic [1:0] blk_last_ff;

   // parameter block words written by host software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_id_ff <= RST_WORD;
         pb_flags_ff <= RST_WORD;
         pb_msg_ff <= RST_WORD;
         xfer_ff <= RST_WORD;
         sense_cnt_ff <= 6'h00;
      end else if (wr_en) begin
         if (paddr == REG_CMD_ID) cmd_id_ff <= pwdata;
         if (paddr == REG_PB_FLAGS) pb_flags_ff <= pwdata;
         if (paddr == REG_PB_MSG) pb_msg_ff <= pwdata;
         if (paddr == REG_XFER) xfer_ff <= pwdata;
         if (paddr == REG_SENSE_CFG) sense_cnt_ff <= pwdata[5:0];
      end
   end

   // selected sense byte indices, four per word
   genvar gi;
   generate
      for (gi = 0; gi < SENSE_SEL_MAX; gi++) begin : g_sel
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sel_ff[gi] <= 8'h00;
            end else if (wr_en &&
                         paddr == REG_SEL_BASE + 8'((gi / 4) * 4)) begin
               sel_ff[gi] <= pwdata[(gi % 4) * 8 +: 8];
            end
         end
      end
   endgenerate

   // ************************************************************
   // message form decode
   // ************************************************************
   logic [7:0] flags2;
   logic [7:0] flags1;
   logic msg_form;
   logic [7:0] mcode;
   logic code_ok;
   assign flags2 = pb_flags_ff[7:0];
   assign flags1 = pb_flags_ff[15:8];
   assign msg_form = flags2[F2_MSG_ONLY_BIT];      // R1 R2
   assign mcode = pb_msg_ff[7:0];                  // R1
   assign code_ok = (mcode == MSG_ABORT) || (mcode == MSG_BDR) ||
                    (mcode == MSG_CLRQ);           // R3

   // ************************************************************
   // control and engine events
   // ************************************************************
   typedef enum logic [2:0] {
      SPM_IDLE, SPM_BUSY, SPM_SENSE, SPM_FILL, SPM_DONE
   } spm_state_t;
   spm_state_t state_ff;
   spm_state_t nxt_state;
   logic done_ff;
   logic start;
   logic ack;
   logic ev_wr;
   spm_ev_t ev_kind;
   // start only taken while idle: a late start would re-raise done
   // over stale fields
   assign start = wr_en && paddr == REG_CTRL && pwdata[0] &&
                  state_ff == SPM_IDLE;                     // R24
   assign ack = wr_en && paddr == REG_CTRL && pwdata[1];
   assign ev_wr = wr_en && paddr == REG_EVT;
   assign ev_kind = spm_ev_t'(pwdata[25:24]);

   // sense byte capture from request sense data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sbuf_wr_ptr_ff <= 8'h00;
      end else if (start) begin
         sbuf_wr_ptr_ff <= 8'h00;
      end else if (wr_en && paddr == REG_SBUF) begin
         sbuf_wr_ptr_ff <= sbuf_wr_ptr_ff + 8'h01;
      end
   end
   generate
      for (gi = 0; gi < SENSE_SEQ_MAX; gi++) begin : g_sbuf
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sbuf_ff[gi] <= 8'h00;
            end else if (start) begin
               sbuf_ff[gi] <= 8'h00;
            end else if (wr_en && paddr == REG_SBUF &&
                         sbuf_wr_ptr_ff == 8'(gi)) begin
               sbuf_ff[gi] <= pwdata[7:0];
            end
         end
      end
   endgenerate

   // ************************************************************
   // sense mode and block count
   // ************************************************************
   logic sel_any;
   logic [1:0] nblk;
   always_comb begin
      sel_any = 1'b0;
      for (int i = 0; i < SENSE_SEL_MAX; i++) begin
         sel_any = sel_any | (sel_ff[i] != 8'h00);
      end
      if (sense_cnt_ff > 6'd8) begin                // R20 R21
         nblk = 2'((32'(sense_cnt_ff) + 32'd7) / 32'd8 - 32'd1);
      end else if (sense_cnt_ff == 6'h00 && sel_any) begin
         nblk = 2'd1;                               // 16 selected
      end else begin
         nblk = 2'd0;                               // R23
      end
   end

   // sense byte lookup for one byte slot of the current block
   function automatic logic [7:0] sense_at(input logic [1:0] blk,
                                           input int slot);
      int k;
      logic [7:0] idx;
      k = int'(blk) * 8 + slot;
      if (sense_cnt_ff == 6'h00 && sel_any) begin
         idx = sel_ff[k[3:0]];
         sense_at = (idx < 8'(SENSE_SEQ_MAX)) ? sbuf_ff[idx[4:0]] : 8'h00;
      end else if (sense_cnt_ff > 6'd8 && 32'(k) >= 32'(sense_cnt_ff)) begin
         sense_at = 8'h00;
      end else begin
         sense_at = sbuf_ff[k[4:0]];
      end
   endfunction : sense_at

   logic sense_wanted;
   assign sense_wanted = !flags1[F1_AUTO_SENSE_INHIBIT_BIT];   // R19

   // ************************************************************
   // command sequencer
   // ************************************************************
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         SPM_IDLE: begin
            if (start) nxt_state = msg_form ? SPM_FILL : SPM_BUSY;
         end
         SPM_BUSY: begin
            if (ev_wr && ev_kind == SPM_EV_STATUS &&
                pwdata[7:0] == ST_CHECK_COND && sense_wanted) begin
               nxt_state = SPM_SENSE;                            // R19
            end else if (ev_wr && ev_kind != SPM_EV_NONE) begin
               nxt_state = SPM_FILL;
            end
         end
         SPM_SENSE: begin
            if (ev_wr && pwdata[26]) nxt_state = SPM_FILL;
         end
         SPM_FILL: nxt_state = SPM_DONE;                          // R24
         SPM_DONE: begin
            if (ack) nxt_state = (blk_idx_ff == blk_last_ff) ?
                                 SPM_IDLE : SPM_FILL;             // R21
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) state_ff <= SPM_IDLE;
      else state_ff <= nxt_state;
   end

   // message form launch toward the bus engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msg_send_ff <= 1'b0;
         msg_code_ff <= 8'h00;
         msg_lun_ff <= 3'h0;
         msg_target_ff <= 8'h00;
      end else begin
         msg_send_ff <= start && msg_form && code_ok;        // R3 R4
         if (start && msg_form) begin
            msg_code_ff <= mcode;                            // R1
            msg_lun_ff <= pb_msg_ff[15:13];                  // R5
            msg_target_ff <= pb_flags_ff[31:24];             // R2
         end
      end
   end

   // request sense strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sense_req_ff <= 1'b0;
      else sense_req_ff <= state_ff == SPM_BUSY && nxt_state == SPM_SENSE;
   end

   // ************************************************************
   // completion result capture
   // ************************************************************
   logic [7:0] scsi_st_ff;
   logic [7:0] err_ff;
   logic [3:0] xflags_ff;     // over, short, retry, error
   logic sense_ok_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scsi_st_ff <= 8'h00;
         err_ff <= 8'h00;
         xflags_ff <= 4'h0;
         sense_ok_ff <= 1'b0;
      end else if (start) begin
         scsi_st_ff <= 8'h00;
         sense_ok_ff <= 1'b0;
         xflags_ff <= 4'h0;
         err_ff <= (msg_form && !code_ok) ? ERR_INVALID_CMD : 8'h00; // R4
         if (msg_form && !code_ok) xflags_ff[3] <= 1'b1;             // R13
      end else if (state_ff == SPM_BUSY && ev_wr) begin
         xflags_ff[0] <= pwdata[8];                                  // R10
         xflags_ff[1] <= pwdata[9];                                  // R11
         xflags_ff[2] <= pwdata[10];                                 // R12
         if (ev_kind == SPM_EV_PHASE) begin
            scsi_st_ff <= {5'h00, pwdata[2:0]};                      // R17 R18
            err_ff <= ERR_UNEXP_PHASE;                               // R17
            xflags_ff[3] <= 1'b1;                                    // R13
         end else if (ev_kind == SPM_EV_STATUS) begin
            scsi_st_ff <= pwdata[7:0] & ST_STATUS_MASK;              // R16
            err_ff <= pwdata[23:16];                                 // R15
            xflags_ff[3] <= pwdata[23:16] != 8'h00 ||
                            pwdata[7:0] == ST_CHECK_COND;            // R13
            sense_ok_ff <= pwdata[7:0] == ST_CHECK_COND && sense_wanted;
         end
      end
   end

   // ************************************************************
   // status block assembly
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blk_idx_ff <= 2'd0;
         blk_last_ff <= 2'd0;
      end else if (start) begin
         blk_idx_ff <= 2'd0;
         blk_last_ff <= 2'd0;
      end else if (state_ff == SPM_DONE && nxt_state == SPM_FILL) begin
         blk_idx_ff <= blk_idx_ff + 2'd1;                  // R21
      end else if (state_ff != SPM_FILL && nxt_state == SPM_FILL) begin
         blk_last_ff <= sense_ok_ff ? nblk : 2'd0;
      end
   end

   // fields written in fill, done flag raised one cycle later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sb_word1_ff <= RST_WORD;
         sb_sense_ff <= 64'h0;
         done_ff <= 1'b0;
      end else if (state_ff == SPM_FILL) begin
         done_ff <= 1'b0;
         sb_word1_ff[7:0] <= 8'h00;                             // R6
         sb_word1_ff[15:8] <= scsi_st_ff;                       // R16
         sb_word1_ff[23:16] <= err_ff;                          // R15
         sb_word1_ff[24 + FL_TMS] <= 1'b0;                      // R8
         sb_word1_ff[24 + FL_ZERO1] <= 1'b0;                    // R8
         sb_word1_ff[24 + FL_CONT] <= blk_idx_ff != 2'd0;       // R9
         sb_word1_ff[24 + FL_OVER] <= xflags_ff[0];             // R10
         sb_word1_ff[24 + FL_SHORT] <= xflags_ff[1];            // R11
         sb_word1_ff[24 + FL_RETRY] <= xflags_ff[2];            // R12
         sb_word1_ff[24 + FL_ERR] <= xflags_ff[3];              // R13
         sb_word1_ff[24 + FL_DONE] <= 1'b0;                     // R24
         for (int s = 0; s < SENSE_DEF; s++) begin
            sb_sense_ff[s * 8 +: 8] <= sense_ok_ff ?
                                       sense_at(blk_idx_ff, s) : 8'h00; // R22
         end
      end else if (state_ff == SPM_DONE && !done_ff) begin
         done_ff <= 1'b1;
         sb_word1_ff[24 + FL_DONE] <= 1'b1;                     // R14
      end else if (start) begin
         done_ff <= 1'b0;
         sb_word1_ff[24 + FL_DONE] <= 1'b0;
      end
   end

   // ************************************************************
   // read mux
   // ************************************************************
   always_comb begin
      prdata = 32'h0;
      pslverr = 1'b0;
      if (rd_en) begin
         unique case (paddr)
            REG_CMD_ID: prdata = cmd_id_ff;
            REG_PB_FLAGS: prdata = pb_flags_ff;
            REG_PB_MSG: prdata = pb_msg_ff;
            REG_XFER: prdata = xfer_ff;
            REG_SENSE_CFG: prdata = {26'h0, sense_cnt_ff};
            REG_SB0: prdata = cmd_id_ff;                        // R7
            REG_SB1: prdata = sb_word1_ff;                      // R6
            REG_SB2: prdata = sb_sense_ff[31:0];
            REG_SB3: prdata = sb_sense_ff[63:32];
            REG_STAT: prdata = {21'h0, msg_lun_ff, 5'h0, 3'(state_ff)};
            default: prdata = 32'h0;
         endcase
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_done_after_fill;
      @(posedge pclk) disable iff (!presetn)
      state_ff == SPM_FILL |=> !sb_word1_ff[31] ##1 sb_word1_ff[31];
   endproperty
   a_done_after_fill: assert property (p_done_after_fill) // R24
      else $error("done flag not after fill");

   property p_bad_code;
      @(posedge pclk) disable iff (!presetn)
      start && msg_form && !code_ok |=> !msg_send_ff &&
         err_ff == ERR_INVALID_CMD;
   endproperty
   a_bad_code: assert property (p_bad_code) // R4
      else $error("invalid message code not rejected");

   property p_good_code;
      @(posedge pclk) disable iff (!presetn)
      start && msg_form && code_ok |=> msg_send_ff ##1 !msg_send_ff;
   endproperty
   a_good_code: assert property (p_good_code) // R3
      else $error("valid message not sent once");

   property p_low_flags;
      @(posedge pclk) disable iff (!presetn)
      $rose(done_ff) |-> sb_word1_ff[25:24] == 2'b00;
   endproperty
   a_low_flags: assert property (p_low_flags) // R8
      else $error("flags bits 1..0 not zero");

   property p_cont;
      @(posedge pclk) disable iff (!presetn)
      $rose(done_ff) |-> sb_word1_ff[26] == (blk_idx_ff != 2'd0);
   endproperty
   a_cont: assert property (p_cont) // R9
      else $error("continued flag wrong");

   property p_phase_err;
      @(posedge pclk) disable iff (!presetn)
      state_ff == SPM_BUSY && ev_wr && ev_kind == SPM_EV_PHASE |=>
         err_ff == ERR_UNEXP_PHASE && xflags_ff[3];
   endproperty
   a_phase_err: assert property (p_phase_err) // R17
      else $error("unexpected phase not posted");

   property p_sense_zero;
      @(posedge pclk) disable iff (!presetn)
      state_ff == SPM_FILL && !sense_ok_ff |=> sb_sense_ff == 64'h0;
   endproperty
   a_sense_zero: assert property (p_sense_zero) // R22
      else $error("sense not zero");

   property p_auto_sense;
      @(posedge pclk) disable iff (!presetn)
      state_ff == SPM_BUSY && ev_wr && ev_kind == SPM_EV_STATUS &&
         pwdata[7:0] == ST_CHECK_COND && sense_wanted |=> sense_req_ff;
   endproperty
   a_auto_sense: assert property (p_auto_sense) // R19
      else $error("request sense not issued");
endmodule : spm_core

// *** shared/spm_pkg.sv ***
package spm_pkg;
   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] REG_CMD_ID = 8'h00;   // command identifier in
   localparam logic [7:0] REG_PB_FLAGS = 8'h04; // flags2,flags1,tgt
   localparam logic [7:0] REG_PB_MSG = 8'h08;   // message code, lun byte
   localparam logic [7:0] REG_XFER = 8'h0c;     // transfer count
   localparam logic [7:0] REG_SENSE_CFG = 8'h10; // sense count
   localparam logic [7:0] REG_SEL_BASE = 8'h14; // 4 words of selected idx
   localparam logic [7:0] REG_CTRL = 8'h24;     // start / ack
   localparam logic [7:0] REG_EVT = 8'h28;      // bus event from engine
   localparam logic [7:0] REG_SBUF = 8'h2c;     // sense byte write port
   localparam logic [7:0] REG_SB0 = 8'h40;      // status block word 0
   localparam logic [7:0] REG_SB1 = 8'h44;
   localparam logic [7:0] REG_SB2 = 8'h48;
   localparam logic [7:0] REG_SB3 = 8'h4c;
   localparam logic [7:0] REG_STAT = 8'h50;     // engine state / lun
   // ************************************************************
   // field positions and codes
   // ************************************************************
   localparam int F2_MSG_ONLY_BIT = 3;          // message_only_select
   localparam int F1_AUTO_SENSE_INHIBIT_BIT = 0; // auto_sense_inhibit
   localparam int FL_TMS = 0;
   localparam int FL_ZERO1 = 1;
   localparam int FL_CONT = 2;   // continued_report_flag
   localparam int FL_OVER = 3;   // transfer_over_flag
   localparam int FL_SHORT = 4;  // transfer_short_flag
   localparam int FL_RETRY = 5;  // retried_flag
   localparam int FL_ERR = 6;
   localparam int FL_DONE = 7;   // done_flag
   localparam logic [7:0] MSG_ABORT = 8'h06;
   localparam logic [7:0] MSG_BDR = 8'h0c;
   localparam logic [7:0] MSG_CLRQ = 8'h0e;
   localparam logic [7:0] ERR_INVALID_CMD = 8'h01;
   localparam logic [7:0] ERR_UNEXP_PHASE = 8'h24;
   localparam logic [7:0] ST_CHECK_COND = 8'h02;
   localparam logic [7:0] ST_STATUS_MASK = 8'h3e; // code bits 5..1
   localparam int SENSE_DEF = 8;
   localparam int SENSE_SEQ_MAX = 32;
   localparam int SENSE_SEL_MAX = 16;
   localparam int SENSE_BUF = 256;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   typedef enum logic [1:0] {
      SPM_EV_NONE, SPM_EV_STATUS, SPM_EV_PHASE
   } spm_ev_t;
endpackage : spm_pkg

// *** bench/spm_target.sv ***
`timescale 1ns/10ps
// ************************************************************
// far-side target model: takes messages and sense requests
// ************************************************************
module spm_target (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic msg_send_ff,
   input wire logic [7:0] msg_code_ff,
   input wire logic [2:0] msg_lun_ff,
   input wire logic [7:0] msg_target_ff,
   input wire logic sense_req_ff,
   output logic [7:0] msg_cnt_ff,
   output logic [7:0] sense_cnt_ff,
   output logic [18:0] last_msg_ff
);
   // a selected target logs one message per send pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msg_cnt_ff <= 8'h00;
         last_msg_ff <= 19'h00000;
      end else if (msg_send_ff) begin
         msg_cnt_ff <= msg_cnt_ff + 8'h01;
         last_msg_ff <= {msg_target_ff, msg_lun_ff, msg_code_ff};
      end
   end
   // each request sense pulse is one command to the target
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_cnt_ff <= 8'h00;
      end else if (sense_req_ff) begin
         sense_cnt_ff <= sense_cnt_ff + 8'h01;
      end
   end
endmodule : spm_target

// *** bench/testbench.sv ***
`timescale 1ns/10ps
module testbench;
   import spm_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, msg_send_ff, sense_req_ff;
   logic [7:0] msg_code_ff, msg_target_ff, msg_cnt, sense_cnt, n0, sb;
   logic [2:0] msg_lun_ff, fl;
   logic [18:0] last_msg;
   logic [31:0] rd, id, r;
   logic [7:0] codes[5] = '{MSG_ABORT, MSG_BDR, MSG_CLRQ, 8'h0d, 8'hff};
   logic [7:0] stats[7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h28};
   logic [7:0] sense_q[$];
   logic [7:0] sel[16] = '{default: 8'h00};
   logic sel_on = 1'b0;
   logic good, inh;
   int fails = 0;
   int compares = 0;
   int cycles = 0;
   int sc, nb;
   // ************************************************************
   // clock, limits, instances
   // ************************************************************
   always #5 pclk = ~pclk;
   // cut a hang short
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails = fails + 1;
         report_and_stop();
      end
   end
   spm_core spm_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .msg_send_ff(msg_send_ff), .msg_code_ff(msg_code_ff),
      .msg_lun_ff(msg_lun_ff), .msg_target_ff(msg_target_ff),
      .sense_req_ff(sense_req_ff));
   spm_target spm_target_i (.pclk(pclk), .presetn(presetn),
      .msg_send_ff(msg_send_ff), .msg_code_ff(msg_code_ff),
      .msg_lun_ff(msg_lun_ff), .msg_target_ff(msg_target_ff),
      .sense_req_ff(sense_req_ff), .msg_cnt_ff(msg_cnt),
      .sense_cnt_ff(sense_cnt), .last_msg_ff(last_msg));
   // ************************************************************
   // tasks
   // ************************************************************
   task report_and_stop();
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares = compares + 1;
      if (g !== e) begin
         fails = fails + 1;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one apb transfer: setup, access until pready at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task start_cmd(input logic [7:0] f1, input logic [7:0] f2,
                  input logic [15:0] mw, input int cnt);
      id = $urandom;
      r = $urandom;
      apb(1'b1, REG_CMD_ID, id);
      apb(1'b1, REG_PB_FLAGS, {r[31:16], f1, f2});
      apb(1'b1, REG_PB_MSG, {r[15:0], mw});
      apb(1'b1, REG_XFER, $urandom);
      apb(1'b1, REG_SENSE_CFG, cnt);
      for (int i = 0; i < 4; i++)
         apb(1'b1, REG_SEL_BASE + 8'(4 * i),
             {sel[4*i+3], sel[4*i+2], sel[4*i+1], sel[4*i]});
      apb(1'b1, REG_CTRL, 32'h1);
   endtask : start_cmd
   task chk_block(input logic [7:0] fl8, input logic [7:0] er,
                  input logic [7:0] st, input int base, input logic [31:0] m);
      int n;
      int j;
      logic [63:0] s;
      n = 0;
      s = 64'h0;
      // selected mode maps each slot through the index table
      for (int i = 0; i < 8; i++) begin
         j = sel_on ? sel[base + i] : base + i;
         if (base >= 0 && j < sense_q.size()) s[8*i +: 8] = sense_q[j];
      end
      do begin
         apb(1'b0, REG_SB1, 32'h0);
         n = n + 1;
      end while (rd[31] !== 1'b1 && n < 40);
      chk("status word", {fl8, er, st, 8'h00} & m, rd & m);
      chk("slave error", 32'h0, {31'h0, pslverr});
      apb(1'b0, REG_SB0, 32'h0);
      chk("command id", id, rd);
      apb(1'b0, REG_SB2, 32'h0);
      chk("sense low", s[31:0], rd);
      apb(1'b0, REG_SB3, 32'h0);
      chk("sense high", s[63:32], rd);
      // host acknowledges: next block or back to idle
      apb(1'b1, REG_CTRL, 32'h2);
   endtask : chk_block
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      void'($urandom(32'hafed));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // message form: three valid codes and two refused ones
      for (int i = 0; i < 5; i++) begin
         good = (i < 3);
         n0 = msg_cnt;
         sb = $urandom;
         start_cmd($urandom, $urandom | 8'h08, {sb, codes[i]}, 0);
         chk_block(good ? 8'h80 : 8'hc0, good ? 8'h00 : ERR_INVALID_CMD, 8'h00,
            -1, 32'hffff00ff);
         chk("message count", {24'h0, n0 + {7'h0, good}},
             {24'h0, msg_cnt});
         if (good) chk("message", {13'h0, r[31:24], sb[7:5], codes[i]},
                       {13'h0, last_msg});
      end
      $display("test message form done");
      // status phase byte with transfer and retry flags
      for (int i = 0; i < 7; i++) begin
         fl = $urandom;
         sb = stats[i] | (8'($urandom) & 8'hc1);
         start_cmd($urandom, $urandom & 8'hf7, $urandom, 0);
         apb(1'b1, REG_EVT, {6'h0, 2'b01, 8'h00, 5'h0, fl, sb});
         chk_block({2'b10, fl, 3'b000}, 8'h00, sb & ST_STATUS_MASK, -1,
            32'hffffffff);
      end
      $display("test status byte done");
      // every bus phase reported as unexpected
      for (int ph = 0; ph < 8; ph++) begin
         start_cmd($urandom, $urandom & 8'hf7, $urandom, 0);
         apb(1'b1, REG_EVT, 32'h0200_0000 | 32'(ph));
         chk_block(8'hc0, ERR_UNEXP_PHASE, 8'(ph), -1, 32'hffff07ff);
      end
      $display("test unexpected phase done");
      // check condition: inhibited, default eight, sixteen sequential,
      // sixteen selected out of 32 buffered bytes
      for (int k = 0; k < 4; k++) begin
         inh = (k == 0);
         sc = (k == 2) ? 16 : 0;
         nb = (k == 3) ? 32 : (k == 2) ? 16 : 8;
         sel_on = (k == 3);
         for (int i = 0; i < 16; i++)
            sel[i] = sel_on ? 8'($urandom % 40) | 8'h01 : 8'h00;
         n0 = sense_cnt;
         sense_q.delete();
         start_cmd({7'($urandom), inh}, $urandom & 8'hf7, $urandom, sc);
         apb(1'b1, REG_EVT, 32'h0100_0000 | 32'(ST_CHECK_COND));
         for (int n = 0; n < 20 && sense_cnt == n0 && !inh; n++) @(posedge pclk);
         chk("sense requests", {24'h0, n0 + {7'h0, !inh}}, {24'h0, sense_cnt});
         if (!inh) begin
            for (int b = 0; b < nb; b++) begin
               sense_q.push_back($urandom);
               apb(1'b1, REG_SBUF, {24'h0, sense_q[b]});
            end
            apb(1'b1, REG_EVT, 32'h0400_0000);
         end
         chk_block(8'hc0, 8'h00, ST_CHECK_COND, inh ? -1 : 0, 32'hffffffff);
         if (k >= 2) begin
            chk_block(8'hc4, 8'h00, ST_CHECK_COND, 8, 32'hffffffff);
         end
      end
      $display("test sense reporting done");
      report_and_stop();
   end
endmodule : testbench
